// File: src/aocr_regs.sv
// aocr_regs: output test and configuration register bank with eight
// output lanes and the divided output clock phase pick.
// assumes the host transfer logic gives one-cycle write and read strobes
// with an address, and that samples arrive on clk_sys with a valid strobe.
`timescale 1ns/100ps
module aocr_regs #(
	parameter int NUM_CH = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [2:0] clk_div_ratio,
	input wire logic [15:0] user_patt1,
	input wire logic [15:0] user_patt2,
	input wire logic sample_valid,
	input wire logic [NUM_CH*14-1:0] sample_bus,
	output logic [7:0] reg_rdata_ff,
	output logic reg_rvalid_ff,
	output logic chop_en_ff,
	output logic [2:0] full_scale_sel_ff,
	output logic [1:0] clk_drive_2x_ff,
	output logic out_clk_en_ff,
	output logic [NUM_CH*14-1:0] out_word_bus,
	output logic [NUM_CH-1:0] out_valid_bus
);
	logic [7:0] dev_index_ff;
	logic [7:0] enh_ctrl_ff;
	logic [7:0] fmt_glob_ff;
	logic [7:0] phase_ff;
	logic [7:0] fs_ff;
	logic [2:0] div_cnt_ff;
	logic [7:0] test_ctrl_ff [NUM_CH];
	logic [7:0] offset_ff [NUM_CH];
	logic [NUM_CH-1:0] invert_ff;
	logic [NUM_CH-1:0] ch_sel;
	logic [7:0] nxt_rdata;
	logic [2:0] rd_ch;
	logic [3:0] phase_eff;

	// lanes pair up behind one index bit each: a1/a2, b1/b2, c1/c2, d1/d2
	function automatic logic [NUM_CH-1:0] lane_sel(input logic [7:0] idx);
		for (int i = 0; i < NUM_CH; i++) begin
			lane_sel[i] = idx[i/2];
		end
	endfunction

	// reads of a per-lane register report the lowest indexed lane
	function automatic logic [2:0] first_lane(input logic [NUM_CH-1:0] sel);
		first_lane = 3'h0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (sel[i]) begin
				first_lane = i[2:0];
			end
		end
	endfunction

	assign ch_sel = lane_sel(dev_index_ff);
	assign rd_ch = first_lane(ch_sel);

	// ------------------------------------------------------------------
	// global registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dev_index_ff <= aocr_pkg::RST_DEV_INDEX;
			enh_ctrl_ff <= aocr_pkg::RST_ZERO;
			fmt_glob_ff <= aocr_pkg::RST_OUT_FORMAT;
			phase_ff <= aocr_pkg::RST_OUT_PHASE;
			fs_ff <= aocr_pkg::RST_FULL_SCALE;
		end else if (reg_wr) begin
			case (reg_addr)
				aocr_pkg::ADDR_DEV_INDEX: dev_index_ff <= reg_wdata & aocr_pkg::MASK_DEV_INDEX;
				aocr_pkg::ADDR_ENH_CTRL: enh_ctrl_ff <= reg_wdata & aocr_pkg::MASK_ENH_CTRL;
				aocr_pkg::ADDR_OUT_FORMAT: begin
					fmt_glob_ff[aocr_pkg::FMT_BIT] <= reg_wdata[aocr_pkg::FMT_BIT];
				end
				aocr_pkg::ADDR_OUT_PHASE: phase_ff <= reg_wdata & aocr_pkg::MASK_OUT_PHASE;
				aocr_pkg::ADDR_FULL_SCALE: fs_ff <= reg_wdata & aocr_pkg::MASK_FULL_SCALE;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// per-lane registers and the two output clock driver bits
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				test_ctrl_ff[i] <= aocr_pkg::RST_ZERO;
				offset_ff[i] <= aocr_pkg::RST_ZERO;
			end
			invert_ff <= '0;
			clk_drive_2x_ff <= 2'h0;
		end else if (reg_wr) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (ch_sel[i]) begin
					if (reg_addr == aocr_pkg::ADDR_TEST_CTRL) begin
						test_ctrl_ff[i] <= reg_wdata & aocr_pkg::MASK_TEST_CTRL;
					end
					if (reg_addr == aocr_pkg::ADDR_OFFSET_TRIM) begin
						offset_ff[i] <= reg_wdata;
					end
					if (reg_addr == aocr_pkg::ADDR_OUT_FORMAT) begin
						invert_ff[i] <= reg_wdata[aocr_pkg::INV_BIT];
					end
				end
			end
			if (reg_addr == aocr_pkg::ADDR_OUT_DRIVER) begin
				if (dev_index_ff[aocr_pkg::IDX_WCLK_BIT]) begin
					clk_drive_2x_ff[0] <= reg_wdata[aocr_pkg::DRIVE_BIT];
				end
				if (dev_index_ff[aocr_pkg::IDX_BCLK_BIT]) begin
					clk_drive_2x_ff[1] <= reg_wdata[aocr_pkg::DRIVE_BIT];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// read back
	// ------------------------------------------------------------------
	always_comb begin
		case (reg_addr)
			aocr_pkg::ADDR_DEV_INDEX: nxt_rdata = dev_index_ff;
			aocr_pkg::ADDR_ENH_CTRL: nxt_rdata = enh_ctrl_ff;
			aocr_pkg::ADDR_TEST_CTRL: nxt_rdata = test_ctrl_ff[rd_ch];
			aocr_pkg::ADDR_OFFSET_TRIM: nxt_rdata = offset_ff[rd_ch];
			aocr_pkg::ADDR_OUT_FORMAT: begin
				nxt_rdata = fmt_glob_ff;
				nxt_rdata[aocr_pkg::INV_BIT] = invert_ff[rd_ch];
			end
			aocr_pkg::ADDR_OUT_DRIVER: begin
				nxt_rdata = 8'h00;
				nxt_rdata[aocr_pkg::DRIVE_BIT] = dev_index_ff[aocr_pkg::IDX_WCLK_BIT] ?
					clk_drive_2x_ff[0] : clk_drive_2x_ff[1];
			end
			aocr_pkg::ADDR_OUT_PHASE: nxt_rdata = phase_ff;
			aocr_pkg::ADDR_FULL_SCALE: nxt_rdata = fs_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata_ff <= 8'h00;
			reg_rvalid_ff <= 1'b0;
		end else begin
			reg_rvalid_ff <= reg_rd;
			if (reg_rd) begin
				reg_rdata_ff <= nxt_rdata;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			chop_en_ff <= 1'b0;
			full_scale_sel_ff <= 3'h0;
		end else begin
			chop_en_ff <= enh_ctrl_ff[aocr_pkg::CHOP_BIT];
			full_scale_sel_ff <= fs_ff[2:0];
		end
	end

	// ------------------------------------------------------------------
	// output clock phase pick
	// ------------------------------------------------------------------
	// only the output clock enable moves; sample_valid is never retimed.
	// an illegal phase above the divide count is folded to the last phase.
	assign phase_eff = (phase_ff[3:0] > aocr_pkg::PHASE_MAX ||
		phase_ff[3:0] > {1'b0, clk_div_ratio}) ? {1'b0, clk_div_ratio} : phase_ff[3:0];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_cnt_ff <= 3'h0;
			out_clk_en_ff <= 1'b0;
		end else begin
			div_cnt_ff <= (div_cnt_ff >= clk_div_ratio) ? 3'h0 : div_cnt_ff + 3'h1;
			out_clk_en_ff <= ({1'b0, div_cnt_ff} == phase_eff);
		end
	end

	// ------------------------------------------------------------------
	// lanes
	// ------------------------------------------------------------------
	for (genvar g = 0; g < NUM_CH; g++) begin : g_lane
		aocr_channel u_lane (
			.clk_sys(clk_sys),
			.rst(rst),
			.sample_valid(sample_valid),
			.sample(sample_bus[g*14 +: 14]),
			.offset_trim(offset_ff[g]),
			.test_sel(test_ctrl_ff[g][3:0]),
			.seq_mode(test_ctrl_ff[g][aocr_pkg::SEQ_LSB +: 2]),
			.fmt_twos(fmt_glob_ff[aocr_pkg::FMT_BIT]),
			.invert(invert_ff[g]),
			.user_patt1(user_patt1),
			.user_patt2(user_patt2),
			.word_ff(out_word_bus[g*14 +: 14]),
			.word_valid_ff(out_valid_bus[g])
		);
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence trim_write_s;
		reg_wr && reg_addr == aocr_pkg::ADDR_OFFSET_TRIM && ch_sel[0];
	endsequence

	chop_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
		reg_wr && reg_addr == aocr_pkg::ADDR_ENH_CTRL
		|-> ##2 chop_en_ff == $past(reg_wdata[aocr_pkg::CHOP_BIT], 2))
		else $error("chop enable does not follow write");
	trim_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		trim_write_s |=> offset_ff[0] == $past(reg_wdata))
		else $error("offset trim not stored for selected lane");
	index_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
		reg_wr && reg_addr == aocr_pkg::ADDR_TEST_CTRL && !ch_sel[NUM_CH-1]
		|=> $stable(test_ctrl_ff[NUM_CH-1]))
		else $error("unselected lane changed on write");
	reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		reg_rvalid_ff && $past(reg_addr) == aocr_pkg::ADDR_FULL_SCALE |-> reg_rdata_ff[7:3] == 5'h00)
		else $error("reserved bits read nonzero");
	phase_legal_a: assert property (@(posedge clk_sys) disable iff (rst)
		phase_ff[7:4] == 4'h0)
		else $error("phase register holds bits above field");
	phase_pick_a: assert property (@(posedge clk_sys) disable iff (rst)
		$stable(clk_div_ratio) && {1'b0, div_cnt_ff} == phase_eff |=> out_clk_en_ff)
		else $error("output clock enable missed selected phase");
	fs_field_a: assert property (@(posedge clk_sys) disable iff (rst)
		reg_wr && reg_addr == aocr_pkg::ADDR_FULL_SCALE |-> ##2 full_scale_sel_ff == $past(reg_wdata[2:0], 2))
		else $error("full scale select not applied");
	test_sub_a: assert property (@(posedge clk_sys) disable iff (rst)
		sample_valid && test_ctrl_ff[0][3:0] == aocr_pkg::AOCR_TP_POS_FS |=> out_word_bus[13:0] == aocr_pkg::WORD_POS_FS)
		else $error("positive full scale pattern missing");
	checker_a: assert property (@(posedge clk_sys) disable iff (rst)
		sample_valid && $past(sample_valid) && test_ctrl_ff[0][3:0] == aocr_pkg::AOCR_TP_CHECKER
		&& $stable(test_ctrl_ff[0]) |=> out_word_bus[13:0] != $past(out_word_bus[13:0]))
		else $error("checkerboard did not alternate");
endmodule

// File: src/aocr_pkg.sv
// aocr_pkg: register map, field layout, reset values and codes for the
// output test and configuration register bank.
// assumes the host transfer logic delivers decoded byte writes and reads.
package aocr_pkg;
	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_DEV_INDEX = 8'h05;
	localparam logic [7:0] ADDR_ENH_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_TEST_CTRL = 8'h0d;
	localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h10;
	localparam logic [7:0] ADDR_OUT_FORMAT = 8'h14;
	localparam logic [7:0] ADDR_OUT_DRIVER = 8'h15;
	localparam logic [7:0] ADDR_OUT_PHASE = 8'h16;
	localparam logic [7:0] ADDR_FULL_SCALE = 8'h18;
	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_DEV_INDEX = 8'h3f;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_OUT_FORMAT = 8'h01;
	localparam logic [7:0] RST_OUT_PHASE = 8'h03;
	localparam logic [7:0] RST_FULL_SCALE = 8'h04;
	// ------------------------------------------------------------------
	// writable bit masks, everything else reads zero
	// ------------------------------------------------------------------
	localparam logic [7:0] MASK_DEV_INDEX = 8'h3f;
	localparam logic [7:0] MASK_ENH_CTRL = 8'h04;
	localparam logic [7:0] MASK_TEST_CTRL = 8'hcf;
	localparam logic [7:0] MASK_OUT_FORMAT = 8'h05;
	localparam logic [7:0] MASK_OUT_DRIVER = 8'h01;
	localparam logic [7:0] MASK_OUT_PHASE = 8'h0f;
	localparam logic [7:0] MASK_FULL_SCALE = 8'h07;
	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int CHOP_BIT = 2;
	localparam int FMT_BIT = 0;
	localparam int INV_BIT = 2;
	localparam int DRIVE_BIT = 0;
	localparam int IDX_WCLK_BIT = 4;
	localparam int IDX_BCLK_BIT = 5;
	localparam int SEQ_LSB = 6;
	localparam logic [3:0] PHASE_MAX = 4'hb;
	// ------------------------------------------------------------------
	// test pattern selector and user sequencing codes
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		AOCR_TP_OFF = 4'b0000,
		AOCR_TP_MID = 4'b0001,
		AOCR_TP_POS_FS = 4'b0010,
		AOCR_TP_NEG_FS = 4'b0011,
		AOCR_TP_CHECKER = 4'b0100,
		AOCR_TP_USER = 4'b1000
	} aocr_tp_t;
	typedef enum logic [1:0] {
		AOCR_SEQ_SINGLE = 2'b00,
		AOCR_SEQ_ALT = 2'b01,
		AOCR_SEQ_SINGLE_ONCE = 2'b10,
		AOCR_SEQ_ALT_ONCE = 2'b11
	} aocr_seq_t;
	// ------------------------------------------------------------------
	// data words (14-bit twos complement)
	// ------------------------------------------------------------------
	localparam logic [13:0] WORD_MID = 14'h0000;
	localparam logic [13:0] WORD_POS_FS = 14'h1fff;
	localparam logic [13:0] WORD_NEG_FS = 14'h2000;
	localparam logic [13:0] WORD_CHECK_A = 14'h2aaa;
	localparam logic [13:0] WORD_CHECK_B = 14'h1555;
endpackage

// File: src/aocr_channel.sv
// aocr_channel: one converter lane's output word path: offset trim,
// format, inversion and test pattern substitution.
// assumes samples arrive as 14-bit twos complement with a valid strobe.
`timescale 1ns/100ps
module aocr_channel (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sample_valid,
	input wire logic [13:0] sample,
	input wire logic [7:0] offset_trim,
	input wire logic [3:0] test_sel,
	input wire logic [1:0] seq_mode,
	input wire logic fmt_twos,
	input wire logic invert,
	input wire logic [15:0] user_patt1,
	input wire logic [15:0] user_patt2,
	output logic [13:0] word_ff,
	output logic word_valid_ff
);
	logic alt_ff;
	logic once_done_ff;
	logic [14:0] sum;
	logic [13:0] trimmed;
	logic [13:0] conv_word;
	logic [13:0] user_word;
	logic [13:0] nxt_word;
	logic user_mode;

	// ------------------------------------------------------------------
	// offset trim and format
	// ------------------------------------------------------------------
	// saturate rather than wrap so a trimmed full scale stays full scale
	always_comb begin
		sum = {sample[13], sample} + {{7{offset_trim[7]}}, offset_trim};
		if (sum[14] != sum[13]) begin
			trimmed = sum[14] ? aocr_pkg::WORD_NEG_FS : aocr_pkg::WORD_POS_FS;
		end else begin
			trimmed = sum[13:0];
		end
		conv_word = fmt_twos ? trimmed : {~trimmed[13], trimmed[12:0]};
		if (invert) begin
			conv_word = ~conv_word;
		end
	end

	// ------------------------------------------------------------------
	// user pattern sequencing
	// ------------------------------------------------------------------
	assign user_mode = (test_sel == aocr_pkg::AOCR_TP_USER);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			alt_ff <= 1'b0;
		end else if (!user_mode && test_sel != aocr_pkg::AOCR_TP_CHECKER) begin
			alt_ff <= 1'b0;
		end else if (sample_valid) begin
			alt_ff <= ~alt_ff;
		end
	end

	// the once modes leave the lane at zero until the selector is changed
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			once_done_ff <= 1'b0;
		end else if (!user_mode || !seq_mode[1]) begin
			once_done_ff <= 1'b0;
		end else if (sample_valid && (seq_mode == aocr_pkg::AOCR_SEQ_SINGLE_ONCE || alt_ff)) begin
			once_done_ff <= 1'b1;
		end
	end

	always_comb begin
		if (once_done_ff) begin
			user_word = aocr_pkg::WORD_MID;
		end else if (seq_mode[0] && alt_ff) begin
			user_word = user_patt2[15:2];
		end else begin
			user_word = user_patt1[15:2];
		end
	end

	// ------------------------------------------------------------------
	// pattern substitution
	// ------------------------------------------------------------------
	always_comb begin
		case (test_sel)
			aocr_pkg::AOCR_TP_OFF: nxt_word = conv_word;
			aocr_pkg::AOCR_TP_MID: nxt_word = aocr_pkg::WORD_MID;
			aocr_pkg::AOCR_TP_POS_FS: nxt_word = aocr_pkg::WORD_POS_FS;
			aocr_pkg::AOCR_TP_NEG_FS: nxt_word = aocr_pkg::WORD_NEG_FS;
			aocr_pkg::AOCR_TP_CHECKER: begin
				nxt_word = alt_ff ? aocr_pkg::WORD_CHECK_B : aocr_pkg::WORD_CHECK_A;
			end
			aocr_pkg::AOCR_TP_USER: nxt_word = user_word;
			default: nxt_word = conv_word;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			word_ff <= 14'h0000;
			word_valid_ff <= 1'b0;
		end else begin
			word_valid_ff <= sample_valid;
			if (sample_valid) begin
				word_ff <= nxt_word;
			end
		end
	end
endmodule

// File: testbench/aocr_host_model.sv
// aocr_host_model: host side of the register strobes, one byte per call.
// assumes the bench calls its tasks in sequence, never two at once.
`timescale 1ns/100ps
module aocr_host_model (
	input wire logic clk_sys,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_ff,
	input wire logic reg_rvalid_ff
);
	// ------------------------------------------------------------------
	// transfers
	// ------------------------------------------------------------------
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// per-lane bytes only land where the index points, so the caller sets it first
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		// released lines show the inverse so stale values never look valid
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		d = reg_rvalid_ff ? reg_rdata_ff : 8'hxx;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

// File: testbench/test_adc_output_test_config_regs.sv
// test_adc_output_test_config_regs: self-checking bench for aocr_regs.
// assumes aocr_host_model drives the register strobes.
`timescale 1ns/100ps
module test_adc_output_test_config_regs;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic reg_wr, reg_rd, reg_rvalid_ff, chop_en_ff, out_clk_en_ff;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, rd, out_valid_bus, t;
	logic sample_valid = 1'b0;
	logic [2:0] clk_div_ratio = 3'h3;
	logic [2:0] full_scale_sel_ff;
	logic [1:0] clk_drive_2x_ff;
	logic [15:0] user_patt1 = 16'h1234;
	logic [15:0] user_patt2 = 16'hbcd8;
	logic [111:0] sample_bus = '0;
	logic [111:0] out_word_bus;
	logic [13:0] smp [8];
	logic [7:0] trim [8];
	logic [13:0] w1;
	logic fmt = 1'b1;
	logic inv = 1'b0;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed = 32'h3f32908e;
	int r0, r2;
	localparam logic [7:0] ra [9] = '{8'h05, 8'h0c, 8'h0d, 8'h10, 8'h14, 8'h15, 8'h16, 8'h18, 8'h20};
	localparam logic [7:0] rv [9] = '{8'h3f, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h04, 8'h00};
	localparam logic [7:0] rm [9] = '{8'h3f, 8'h04, 8'hcf, 8'hff, 8'h05, 8'h01, 8'h0f, 8'h07, 8'h00};
	localparam logic [3:0] tc [3] = '{4'h1, 4'h2, 4'h3};
	localparam logic [13:0] tw [3] = '{14'h0000, 14'h1fff, 14'h2000};
	// ------------------------------------------------------------------
	// clock, timeout, instances
	// ------------------------------------------------------------------
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end
	aocr_host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
		.reg_rvalid_ff(reg_rvalid_ff));
	aocr_regs #(.NUM_CH(8)) dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.clk_div_ratio(clk_div_ratio), .user_patt1(user_patt1), .user_patt2(user_patt2),
		.sample_valid(sample_valid), .sample_bus(sample_bus), .reg_rdata_ff(reg_rdata_ff),
		.reg_rvalid_ff(reg_rvalid_ff), .chop_en_ff(chop_en_ff),
		.full_scale_sel_ff(full_scale_sel_ff), .clk_drive_2x_ff(clk_drive_2x_ff),
		.out_clk_en_ff(out_clk_en_ff), .out_word_bus(out_word_bus),
		.out_valid_bus(out_valid_bus));
	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (num_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// saturating trim, then format, then invert
	function automatic logic [13:0] conv(input logic [13:0] s, input logic [7:0] tr);
		int v;
		logic [13:0] w;
		v = $signed(s) + $signed(tr);
		if (v > 8191) v = 8191;
		if (v < -8192) v = -8192;
		w = v[13:0];
		if (!fmt) w[13] = ~w[13];
		if (inv) w = ~w;
		return w;
	endfunction
	function automatic logic [13:0] user_exp(input logic [1:0] sq, input int k);
		if (k == 0) return user_patt1[15:2];
		if (k == 1 && sq[0]) return user_patt2[15:2];
		return sq[1] ? 14'h0000 : user_patt1[15:2];
	endfunction
	task automatic pulse();
		@(negedge clk_sys);
		for (int g = 0; g < 8; g++) sample_bus[g*14 +: 14] = smp[g];
		sample_valid = 1'b1;
		@(negedge clk_sys);
		sample_valid = 1'b0;
		check("out_valid_bus", out_valid_bus, 8'hff);
	endtask
	// lanes in sel show pattern p, the rest conversion data
	task automatic lanes(input logic [7:0] sel, input logic [13:0] p);
		for (int g = 0; g < 8; g++) begin
			check("out_word", out_word_bus[g*14 +: 14], sel[g] ? p : conv(smp[g], trim[g]));
		end
	endtask
	task automatic rnd();
		for (int g = 0; g < 8; g++) smp[g] = $random(seed);
	endtask
	task automatic res(output int r);
		int n;
		n = 0;
		repeat (3) @(negedge clk_sys);
		repeat (8) begin
			@(negedge clk_sys);
			if (out_clk_en_ff === 1'b1) begin
				n++;
				r = cyc % 4;
			end
		end
		check("clk_pulses", n, 16'h0002);
	endtask
	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		foreach (trim[g]) trim[g] = 8'h00;
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		check("full_scale", full_scale_sel_ff, 3'h4);
		check("chop", chop_en_ff, 1'b0);
		foreach (ra[k]) begin
			host.read_reg(ra[k], rd);
			check("reset_val", rd, rv[k]);
			host.write_reg(ra[k], 8'hff);
			host.read_reg(ra[k], rd);
			check("mask", rd, rm[k]);
			host.write_reg(ra[k], rv[k]);
		end
		host.write_reg(8'h0c, 8'h04);
		host.write_reg(8'h18, 8'hfa);
		host.write_reg(8'h15, 8'h01);
		repeat (2) @(negedge clk_sys);
		check("chop", chop_en_ff, 1'b1);
		check("full_scale", full_scale_sel_ff, 3'h2);
		check("drive", clk_drive_2x_ff, 2'b11);
		// trim sweep with saturation corners on lanes 0 and 1
		for (int it = 0; it < 8; it++) begin
			t = (it == 0) ? 8'h7f : (it == 1) ? 8'h80 : $random(seed);
			host.write_reg(8'h10, t);
			foreach (trim[g]) trim[g] = t;
			rnd();
			smp[0] = 14'h1fff;
			smp[1] = 14'h2000;
			pulse();
			lanes(8'h00, 14'h0000);
		end
		for (int f = 0; f < 2; f++) begin
			host.write_reg(8'h14, f ? 8'h04 : 8'h00);
			fmt = 1'b0;
			inv = f[0];
			rnd();
			pulse();
			lanes(8'h00, 14'h0000);
		end
		host.write_reg(8'h14, 8'h01);
		fmt = 1'b1;
		inv = 1'b0;
		// index steers per-lane writes
		host.write_reg(8'h05, 8'h02);
		host.write_reg(8'h10, 8'h05);
		trim[2] = 8'h05;
		trim[3] = 8'h05;
		host.read_reg(8'h10, rd);
		check("trim_lane2", rd, 8'h05);
		host.write_reg(8'h0d, 8'h02);
		rnd();
		pulse();
		lanes(8'h0c, 14'h1fff);
		host.write_reg(8'h0d, 8'h00);
		host.write_reg(8'h05, 8'h10);
		host.write_reg(8'h15, 8'h00);
		repeat (2) @(negedge clk_sys);
		check("drive", clk_drive_2x_ff, 2'b10);
		host.write_reg(8'h05, 8'h3f);
		// fixed patterns ignore the sequencing bits
		foreach (tc[k]) begin
			host.write_reg(8'h0d, {2'b11, 2'b00, tc[k]});
			repeat (2) begin
				rnd();
				pulse();
				lanes(8'hff, tw[k]);
			end
		end
		host.write_reg(8'h0d, 8'h04);
		pulse();
		w1 = out_word_bus[13:0];
		pulse();
		check("checker_xor", w1 ^ out_word_bus[13:0], 14'h3fff);
		check("checker_a", w1, 14'h2aaa);
		// back-to-back samples so the alternation is also seen without idle gaps
		@(negedge clk_sys);
		sample_valid = 1'b1;
		repeat (3) @(negedge clk_sys);
		sample_valid = 1'b0;
		check("checker_burst", out_word_bus[13:0], 14'h2aaa);
		for (int sq = 0; sq < 4; sq++) begin
			host.write_reg(8'h0d, 8'h00);
			host.write_reg(8'h0d, {sq[1:0], 6'h08});
			for (int k = 0; k < 3; k++) begin
				pulse();
				lanes(8'hff, user_exp(sq[1:0], k));
			end
		end
		host.write_reg(8'h0d, 8'h00);
		// phase shift moves the output clock pulse within the divide period
		host.write_reg(8'h16, 8'h00);
		res(r0);
		host.write_reg(8'h16, 8'h02);
		res(r2);
		check("phase_shift", (r2 - r0 + 4) % 4, 16'h0002);
		close_out();
	end
endmodule
